/* File: verif/test_ufc_flow_baud.sv */
// Self-checking bench for the flow control and baud block
`default_nettype none
module test_ufc_flow_baud
  import ufc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic rx_in_valid = 1'b0, rx_in_ready, rx_out_valid, rx_out_ready = 1'b0;
  ufc_rx_char_type rx_in = '0;
  logic [7:0] rx_out_data, tx_in_data = 8'h00, tx_out_data, rx_level = 8'h00;
  logic tx_in_valid = 1'b0, tx_in_ready, tx_out_valid, tx_out_ready;
  logic nine_bit_mode = 1'b0, cts_n, dsr_n, rts_n, dtr_n, level5_irq;
  logic sample_tick, bit_tick, slow = 1'b0, hold_off = 1'b0;
  logic [7:0] last_char, char_count, rx_got = 8'h00, rx_cnt = 8'h00;
  int bad_count = 0;
  int tests_run = 0;

  ufc_flow_baud dut (.clk, .srst, .reg_wr, .reg_rd, .reg_index, .reg_wdata,
    .reg_rdata, .rx_in_valid, .rx_in, .rx_in_ready, .rx_out_valid,
    .rx_out_data, .rx_out_ready, .tx_in_valid, .tx_in_data, .tx_in_ready,
    .tx_out_valid, .tx_out_data, .tx_out_ready, .rx_level, .nine_bit_mode,
    .cts_n, .dsr_n, .rts_n, .dtr_n, .level5_irq, .sample_tick, .bit_tick);
  ufc_remote_model remote (.clk, .slow, .hold_off, .tx_out_valid,
    .tx_out_data, .tx_out_ready, .cts_n, .dsr_n, .last_char, .char_count);

  initial
  begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (rx_out_valid === 1'b1 && rx_out_ready)
    begin
      rx_got <= rx_out_data;
      rx_cnt <= rx_cnt + 8'h01;
    end
  end

  task automatic results();
    $display("compares=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_index <= idx;
    reg_wdata <= val;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] mask,
                       input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_index <= idx;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check({8'h00, reg_rdata & mask}, {8'h00, exp});
  endtask : rdchk

  // Held until the design takes it, released at the taking edge
  task automatic rx_send(input logic [7:0] d, input logic err);
    int n;
    n = 0;
    @(posedge clk);
    rx_in_valid <= 1'b1;
    rx_in <= '{data: d, parity_err: err, framing_err: err};
    @(negedge clk);
    while (rx_in_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    check(n >= 50, 1'b0);
    @(posedge clk);
    rx_in_valid <= 1'b0;
  endtask : rx_send

  task automatic tx_send(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    tx_in_valid <= 1'b1;
    tx_in_data <= d;
    @(negedge clk);
    while (tx_in_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    check(n >= 50, 1'b0);
    @(posedge clk);
    tx_in_valid <= 1'b0;
  endtask : tx_send

  // Offers a character, expects it held back, then withdraws it so a
  // later send is not doubled
  task automatic tx_blocked(input logic [7:0] d);
    logic [7:0] c0;
    c0 = char_count;
    @(posedge clk);
    tx_in_valid <= 1'b1;
    tx_in_data <= d;
    idle(4);
    check(tx_in_ready, 1'b0);
    check(char_count, c0);
    @(posedge clk);
    tx_in_valid <= 1'b0;
  endtask : tx_blocked

  // Skips partial intervals after a change, then counts one bit time
  task automatic baud(input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    repeat (2) @(posedge bit_tick);
    do
    begin
      @(posedge clk);
      n++;
      #1;
    end
    while (bit_tick !== 1'b1 && n < 16'h2000);
    check(n, exp);
  endtask : baud

  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    results();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rdchk(IDX_CPR, 8'hFF, CPR_RESET);
    rdchk(IDX_TCR, 8'hFF, 8'h00);
    rdchk(8'h7F, 8'hFF, 8'h00);
    rx_send(8'hA1, 1'b0);
    rx_send(8'hA2, 1'b0);
    idle(1);
    check(rx_in_ready, 1'b0);
    @(posedge clk) rx_out_ready <= 1'b1;
    idle(4);
    check(rx_got, 8'hA2);
    check(rx_cnt, 8'h02);
    $display("reset and buffer test done");
    baud(16'd16);
    wr(IDX_DLL, 8'h03);
    baud(16'd48);
    wr(IDX_DLM, 8'h01);
    wr(IDX_DLL, 8'h00);
    baud(16'd4096);
    wr(IDX_DLM, 8'h00);
    wr(IDX_DLL, 8'h01);
    wr(IDX_TCR, 8'h04);
    baud(16'd4);
    wr(IDX_EFR, 8'h10);
    wr(IDX_MCR, 8'h80);
    wr(IDX_CPR, 8'h14);
    rdchk(IDX_CPR, 8'hFF, 8'h14);
    baud(16'd10);
    wr(IDX_MCR, 8'h00);
    baud(16'd4);
    wr(IDX_EFR, 8'h00);
    wr(IDX_MCR, 8'h80);
    baud(16'd4);
    $display("baud test done");
    wr(IDX_EFR, 8'h12);
    wr(IDX_FIRST_STOP_CHAR, 8'h13);
    wr(IDX_FIRST_RESUME_CHAR, 8'h11);
    wr(IDX_IER, 8'h20);
    rx_send(8'h13, 1'b1);
    idle(3);
    check(level5_irq, 1'b1);
    rdchk(IDX_ASR, 8'h01, 8'h01);
    rdchk(IDX_ISR, 8'h10, 8'h10);
    tx_blocked(8'h41);
    rx_send(8'h11, 1'b1);
    tx_send(8'h41);
    idle(3);
    check(last_char, 8'h41);
    rdchk(IDX_ASR, 8'h01, 8'h00);
    check(rx_cnt, 8'h02);
    wr(IDX_EFR, 8'h11);
    wr(IDX_SECOND_STOP_CHAR, 8'h93);
    wr(IDX_SECOND_RESUME_CHAR, 8'h91);
    rx_send(8'h13, 1'b0);
    rx_send(8'h93, 1'b0);
    idle(3);
    rdchk(IDX_ASR, 8'h01, 8'h01);
    check(rx_cnt, 8'h03);
    wr(IDX_MCR, 8'h20);
    rx_send(8'h5A, 1'b0);
    idle(3);
    rdchk(IDX_ASR, 8'h01, 8'h00);
    check(rx_got, 8'h5A);
    wr(IDX_MCR, 8'h00);
    wr(IDX_EFR, 8'h31);
    rx_send(8'h93, 1'b0);
    idle(3);
    check(rx_cnt, 8'h05);
    rdchk(IDX_ASR, 8'h11, 8'h11);
    rdchk(IDX_ASR, 8'h10, 8'h00);
    rx_send(8'h91, 1'b0);
    $display("in-band receive test done");
    wr(IDX_EFR, 8'h18);
    @(posedge clk) nine_bit_mode <= 1'b1;
    @(posedge clk) rx_level <= 8'h61;
    idle(10);
    check(char_count, 8'h01);
    @(posedge clk) nine_bit_mode <= 1'b0;
    idle(10);
    check(last_char, 8'h13);
    rdchk(IDX_ASR, 8'h02, 8'h02);
    @(posedge clk) rx_level <= 8'h10;
    idle(10);
    check(last_char, 8'h11);
    check(char_count, 8'h03);
    @(posedge clk) slow <= 1'b1;
    @(posedge clk) rx_level <= 8'h61;
    idle(10);
    wr(IDX_EFR, 8'h10);
    idle(10);
    check(last_char, 8'h11);
    check(char_count, 8'h05);
    @(posedge clk) slow <= 1'b0;
    $display("in-band transmit test done");
    wr(IDX_EFR, 8'hD0);
    wr(IDX_MCR, 8'h03);
    wr(IDX_ACR, 8'h0C);
    @(posedge clk) rx_level <= 8'h10;
    idle(3);
    check({rts_n, dtr_n}, 2'b00);
    @(posedge clk) rx_level <= 8'h60;
    idle(3);
    check({rts_n, dtr_n}, 2'b11);
    @(posedge clk) rx_level <= 8'h10;
    idle(3);
    check({rts_n, dtr_n}, 2'b00);
    wr(IDX_MCR, 8'h01);
    idle(2);
    check({rts_n, dtr_n}, 2'b10);
    @(posedge clk) hold_off <= 1'b1;
    // Let the pin pass the two-stage synchroniser first
    idle(2);
    tx_blocked(8'h42);
    @(posedge clk) hold_off <= 1'b0;
    tx_send(8'h42);
    idle(3);
    check(last_char, 8'h42);
    wr(IDX_ACR, 8'h00);
    wr(IDX_EFR, 8'h00);
    wr(IDX_MCR, 8'h22);
    @(posedge clk) rx_level <= 8'h60;
    idle(3);
    check(rts_n, 1'b1);
    @(posedge clk) rx_level <= 8'h10;
    idle(3);
    check(rts_n, 1'b0);
    $display("out-of-band test done");
    results();
  end
endmodule : test_ufc_flow_baud
`default_nettype wire

/* File: verif/ufc_remote_model.sv */
// Remote serial device: takes transmitted characters, drives modem inputs
`default_nettype none
module ufc_remote_model
  import ufc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       hold_off,
  input  wire logic       tx_out_valid,
  input  wire logic [7:0] tx_out_data,
  output logic            tx_out_ready,
  output logic            cts_n,
  output logic            dsr_n,
  output var logic [7:0]  last_char,
  output var logic [7:0]  char_count
);
  logic phase = 1'b0;
  // Slow mode takes a character only every other cycle, like a busy shifter
  assign tx_out_ready = ~slow | phase;
  // Stop is signalled with the inactive (high) level on both modem lines
  assign cts_n = hold_off;
  assign dsr_n = hold_off;
  initial
  begin
    last_char = 8'h00;
    char_count = 8'h00;
  end
  always @(posedge clk)
  begin
    phase <= ~phase;
    if (tx_out_valid === 1'b1 && tx_out_ready)
    begin
      last_char  <= tx_out_data;
      char_count <= char_count + 8'h01;
    end
  end
endmodule : ufc_remote_model
`default_nettype wire

/* File: verilog/ufc_flow_baud.sv */
// Flow control and baud generation for one UART channel
`default_nettype none
// How it works
// - Enhanced mode with detection on: second stop char sets special flag, interrupt.
// - Reading the additional status register clears the special flag.
// - Character matching ignores parity and framing errors.
// - Stop char halts transmit after current char, sets status, interrupt.
// - While halted, a matching resume char restarts transmit, clears status.
// - Flow chars are not stored, except second stop char with detection on.
// - Resume-on-any makes any char except a stop char resume transmit; that char is stored unless it is a resume char.
// - Transmit flow sampling happens only while transmitter idle; inserts char.
// - Stop sent above upper trigger, resume sent below lower trigger.
// - Disabling transmit flow while stopped sends resume automatically.
// - Normal mode: one bit enables RTS and CTS; enhanced: separate bits.
// - Automatic CTS stops transmission between characters while CTS says stop.
// - Automatic RTS goes inactive at upper trigger, active below lower.
// - Automatic RTS is ANDed with the software RTS bit.
// - DTR/DSR flow control works like RTS/CTS, enabled by control field.
// - Divisor is low byte plus 256 times high byte.
// - Bit rate is clock over samples times divisor times prescaler.
// - Prescaler divides by M plus N/8 when selected.
// - Prescaler bypassed as divide by one when not selected.
// - After reset prescaler bypassed and sample register zero, 16 samples.
// - Prescaler register sits at index 0x01.
// - Enhanced bits ignored and in-band flow off unless enhanced mode.
// - Receive code 01 second pair, 10 first pair, 11 both.
// - Nine-bit framing disables all in-band flow control.
module ufc_flow_baud
  import ufc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_index,
  input  wire logic [7:0]      reg_wdata,
  output logic      [7:0]      reg_rdata,
  input  wire logic            rx_in_valid,
  input  wire ufc_rx_char_type rx_in,
  output logic                 rx_in_ready,
  output logic                 rx_out_valid,
  output logic      [7:0]      rx_out_data,
  input  wire logic            rx_out_ready,
  input  wire logic            tx_in_valid,
  input  wire logic [7:0]      tx_in_data,
  output logic                 tx_in_ready,
  output logic                 tx_out_valid,
  output logic      [7:0]      tx_out_data,
  input  wire logic            tx_out_ready,
  input  wire logic [7:0]      rx_level,
  input  wire logic            nine_bit_mode,
  input  wire logic            cts_n,
  input  wire logic            dsr_n,
  output logic                 rts_n,
  output logic                 dtr_n,
  output logic                 level5_irq,
  output logic                 sample_tick,
  output logic                 bit_tick
);
  logic [7:0] enhanced_features_reg, modem_control_reg, additional_control_reg, interrupt_enable_reg, clock_prescaler, sample_clock_count_reg, dll, divisor_high_byte;
  logic [7:0] first_resume_char, second_resume_char, first_stop_char, second_stop_char, upper, lower;
  logic       rhalt, xsent, xsent_p2, spec, rts_hold;
  logic       cts_m, cts_s, dsr_m, dsr_s;
  logic       v0, v1;
  logic [7:0] d0, d1;
  logic [8:0] pacc;
  logic [15:0] dcnt;
  logic [4:0] scnt;

  // Enhanced gating of in-band and out-of-band controls
  wire enh = enhanced_features_reg[EFR_ENH];
  wire inband_ok = enh & ~nine_bit_mode;
  wire [1:0] rmode = inband_ok ? enhanced_features_reg[1:0] : UFC_FLOW_OFF;
  wire [1:0] tmode = inband_ok ? enhanced_features_reg[3:2] : UFC_FLOW_OFF;
  // Reserved transmit code 11 is treated as off
  wire tflow_on = (tmode == UFC_FLOW_PAIR1) | (tmode == UFC_FLOW_PAIR2);
  wire auto_rts = enh ? enhanced_features_reg[EFR_ARTS] : modem_control_reg[MCR_XANY];
  wire auto_cts = enh ? enhanced_features_reg[EFR_ACTS] : modem_control_reg[MCR_XANY];
  wire auto_dsr = additional_control_reg[ACR_ADSR];
  wire auto_dtr = additional_control_reg[ACR_ADTR];

  // Receive matching works on data bits only, status bits are ignored
  wire [7:0] rc = rx_in.data;
  wire accept = rx_in_valid & rx_in_ready;
  wire use1 = rmode[1];
  wire use2 = rmode[0];
  wire m_n1 = rc == first_resume_char;
  wire m_n2 = rc == second_resume_char;
  wire m_f1 = rc == first_stop_char;
  wire m_f2 = rc == second_stop_char;
  wire xoff_hit = (use1 & m_f1) | (use2 & m_f2);
  wire xon_hit = (use1 & m_n1) | (use2 & m_n2);
  wire spec_hit = enh & enhanced_features_reg[EFR_SPEC] & m_f2;
  wire xany = enh & modem_control_reg[MCR_XANY] & rhalt;
  wire resume = rhalt & (xon_hit | xany);
  wire drop = xon_hit | (xoff_hit & ~spec_hit);
  wire push = accept & ~drop;
  wire pop = v0 & rx_out_ready;
  wire asr_rd = reg_rd & (reg_index == IDX_ASR);

  // Transmit selection; flow chars bypass the halt so the remote is told
  wire slot_free = ~tx_out_valid | tx_out_ready;
  wire need_xoff = tflow_on & ~xsent & (rx_level > upper);
  wire need_xon = xsent & (~tflow_on | (rx_level < lower));
  wire tx_halt = rhalt | (auto_cts & cts_s) | (auto_dsr & dsr_s);
  wire cur_p2 = tmode == UFC_FLOW_PAIR2;
  ufc_src_type src;
  assign src = ~slot_free ? UFC_SRC_NONE
             : need_xoff ? UFC_SRC_XOFF
             : need_xon ? UFC_SRC_XON
             : (tx_in_valid & ~tx_halt) ? UFC_SRC_DATA
             : UFC_SRC_NONE;
  assign tx_in_ready = slot_free & ~need_xoff & ~need_xon & ~tx_halt;
  assign rx_in_ready = ~v1;

  // Baud chain: fractional prescaler in eighths, divisor, sample count
  wire psel = modem_control_reg[MCR_PSEL];
  wire [8:0] pval = (psel && clock_prescaler >= PRESC_STEP[7:0]) ? {1'b0, clock_prescaler}
                  : PRESC_ONE;
  wire [8:0] psum = pacc + PRESC_STEP;
  wire ptick = psum >= pval;
  wire [15:0] divisor = {divisor_high_byte, dll};
  wire [15:0] dnext = dcnt + 16'h0001;
  wire stick = ptick & (dnext >= divisor);
  wire [4:0] sc = (sample_clock_count_reg[3:0] < TCR_MIN) ? SC_DEFAULT
                : {1'b0, sample_clock_count_reg[3:0]};
  wire [4:0] snext = scnt + 5'h01;
  wire btick = stick & (snext >= sc);

  logic [7:0] rd_mux;
  always_comb
  begin
    case (reg_index)
      IDX_CPR:   rd_mux = clock_prescaler;
      IDX_TCR:   rd_mux = sample_clock_count_reg;
      IDX_EFR:   rd_mux = enhanced_features_reg;
      IDX_MCR:   rd_mux = modem_control_reg;
      IDX_ACR:   rd_mux = additional_control_reg;
      IDX_IER:   rd_mux = interrupt_enable_reg;
      IDX_ISR:   rd_mux = {3'b000, rhalt, 4'h0};
      IDX_ASR:   rd_mux = {3'b000, spec, 2'b00, xsent, rhalt};
      IDX_DLL:   rd_mux = dll;
      IDX_DLM:   rd_mux = divisor_high_byte;
      IDX_FIRST_RESUME_CHAR:  rd_mux = first_resume_char;
      IDX_SECOND_RESUME_CHAR:  rd_mux = second_resume_char;
      IDX_FIRST_STOP_CHAR: rd_mux = first_stop_char;
      IDX_SECOND_STOP_CHAR: rd_mux = second_stop_char;
      IDX_UPPER: rd_mux = upper;
      IDX_LOWER: rd_mux = lower;
      default:   rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {enhanced_features_reg, modem_control_reg, additional_control_reg, interrupt_enable_reg} <= {4{ZERO_RESET}};
      {first_resume_char, second_resume_char, first_stop_char, second_stop_char} <= {4{ZERO_RESET}};
      clock_prescaler <= CPR_RESET;
      sample_clock_count_reg <= TCR_RESET;
      dll <= DLL_RESET;
      divisor_high_byte <= ZERO_RESET;
      upper <= UPPER_RESET;
      lower <= LOWER_RESET;
      reg_rdata <= 8'h00;
    end
    else
    begin
      if (reg_rd)
        reg_rdata <= rd_mux;
      if (reg_wr)
      begin
        case (reg_index)
          IDX_CPR:   clock_prescaler <= reg_wdata;
          IDX_TCR:   sample_clock_count_reg <= reg_wdata;
          IDX_EFR:   enhanced_features_reg <= reg_wdata;
          // Bits 7:6 frozen outside enhanced mode; bit 5 stays writable
          // because it enables out-of-band flow in normal mode
          IDX_MCR:   modem_control_reg <= enh ? reg_wdata
                          : {modem_control_reg[7:6], reg_wdata[5:0]};
          IDX_ACR:   additional_control_reg <= reg_wdata;
          IDX_IER:   interrupt_enable_reg <= reg_wdata;
          IDX_DLL:   dll <= reg_wdata;
          IDX_DLM:   divisor_high_byte <= reg_wdata;
          IDX_FIRST_RESUME_CHAR:  first_resume_char <= reg_wdata;
          IDX_SECOND_RESUME_CHAR:  second_resume_char <= reg_wdata;
          IDX_FIRST_STOP_CHAR: first_stop_char <= reg_wdata;
          IDX_SECOND_STOP_CHAR: second_stop_char <= reg_wdata;
          IDX_UPPER: upper <= reg_wdata;
          IDX_LOWER: lower <= reg_wdata;
          default:   ;
        endcase
      end
    end
  end

  // Status flags; a new event in the read cycle wins over the clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rhalt <= 1'b0;
      spec <= 1'b0;
      level5_irq <= 1'b0;
    end
    else
    begin
      if (accept & xoff_hit)
        rhalt <= 1'b1;
      else if (accept & resume)
        rhalt <= 1'b0;
      if (accept & spec_hit)
        spec <= 1'b1;
      else if (asr_rd)
        spec <= 1'b0;
      level5_irq <= enh & interrupt_enable_reg[IER_LVL5] & (rhalt | spec);
    end
  end

  // Two-entry receive buffer; head register drives the outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      v0 <= 1'b0;
      v1 <= 1'b0;
      d0 <= 8'h00;
      d1 <= 8'h00;
    end
    else if (pop)
    begin
      v0 <= v1 | push;
      d0 <= v1 ? d1 : rc;
      v1 <= v1 & push;
      if (v1)
        d1 <= rc;
    end
    else if (push)
    begin
      if (!v0)
      begin
        v0 <= 1'b1;
        d0 <= rc;
      end
      else
      begin
        v1 <= 1'b1;
        d1 <= rc;
      end
    end
  end
  assign rx_out_valid = v0;
  assign rx_out_data = d0;

  // Transmit output stage; only loaded when the shifter is idle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_out_valid <= 1'b0;
      tx_out_data <= 8'h00;
      xsent <= 1'b0;
      xsent_p2 <= 1'b0;
    end
    else
    begin
      if (tx_out_ready)
        tx_out_valid <= 1'b0;
      case (src)
        UFC_SRC_XOFF:
        begin
          tx_out_valid <= 1'b1;
          tx_out_data <= cur_p2 ? second_stop_char : first_stop_char;
          xsent <= 1'b1;
          xsent_p2 <= cur_p2;
        end
        UFC_SRC_XON:
        begin
          tx_out_valid <= 1'b1;
          tx_out_data <= xsent_p2 ? second_resume_char : first_resume_char;
          xsent <= 1'b0;
        end
        UFC_SRC_DATA:
        begin
          tx_out_valid <= 1'b1;
          tx_out_data <= tx_in_data;
        end
        default: ;
      endcase
    end
  end

  // Modem lines: synchronise inputs, register outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {cts_m, cts_s, dsr_m, dsr_s} <= 4'hF;
      rts_hold <= 1'b0;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end
    else
    begin
      cts_m <= cts_n;
      cts_s <= cts_m;
      dsr_m <= dsr_n;
      dsr_s <= dsr_m;
      if (rx_level >= upper)
        rts_hold <= 1'b1;
      else if (rx_level < lower)
        rts_hold <= 1'b0;
      rts_n <= ~(modem_control_reg[MCR_RTS] & ~(auto_rts & rts_hold));
      dtr_n <= ~(modem_control_reg[MCR_DTR] & ~(auto_dtr & rts_hold));
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pacc <= 9'h000;
      dcnt <= 16'h0000;
      scnt <= 5'h00;
      sample_tick <= 1'b0;
      bit_tick <= 1'b0;
    end
    else
    begin
      pacc <= ptick ? psum - pval : psum;
      if (ptick)
        dcnt <= stick ? 16'h0000 : dnext;
      if (stick)
        scnt <= btick ? 5'h00 : snext;
      sample_tick <= stick;
      bit_tick <= btick;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_spec_flag: assert property (accept && spec_hit |=> spec)
    else $error("special flag not set");
  a_asr_rdclr: assert property (asr_rd && !(accept && spec_hit)
    |=> !spec)
    else $error("special flag not cleared by read");
  a_err_match: assert property (accept && xoff_hit && rx_in.parity_err
    |=> rhalt)
    else $error("errored stop char ignored");
  a_halt_irq: assert property (accept && xoff_hit && enh
    && interrupt_enable_reg[IER_LVL5] |=> ##1 level5_irq)
    else $error("level 5 interrupt missing");
  a_resume_tx: assert property (rhalt && accept && xon_hit
    && !xoff_hit |=> !rhalt)
    else $error("resume char ignored");
  a_drop_flow: assert property (accept && xon_hit |-> !push)
    else $error("resume char stored");
  a_halt_data: assert property (tx_halt |-> src != UFC_SRC_DATA)
    else $error("data sent while halted");
  a_xoff_send: assert property (slot_free && need_xoff
    |=> tx_out_valid && xsent)
    else $error("stop char not sent");
  a_rts_soft: assert property (!modem_control_reg[MCR_RTS] |=> rts_n)
    else $error("rts active with software bit clear");
  a_presc_byp: assert property (!psel && !$past(psel) |-> ptick)
    else $error("prescaler not bypassed");
  c_halt_resume: cover property (rhalt ##[1:50] !rhalt);
  c_xoff_xon: cover property (xsent ##[1:200] !xsent);
  c_buf_full: cover property (v1 && !rx_out_ready);
  c_bit_tick: cover property (bit_tick && psel);
endmodule : ufc_flow_baud
`default_nettype wire

/* File: verilog/ufc_pkg.sv */
// Shared constants and types for the UART flow control and baud block
`default_nettype none
package ufc_pkg;
  // Register indices on the indexed register port
  localparam logic [7:0] IDX_CPR   = 8'h01;
  localparam logic [7:0] IDX_TCR   = 8'h02;
  localparam logic [7:0] IDX_EFR   = 8'h10;
  localparam logic [7:0] IDX_MCR   = 8'h11;
  localparam logic [7:0] IDX_ACR   = 8'h12;
  localparam logic [7:0] IDX_IER   = 8'h13;
  localparam logic [7:0] IDX_ISR   = 8'h14;
  localparam logic [7:0] IDX_ASR   = 8'h15;
  localparam logic [7:0] IDX_DLL   = 8'h16;
  localparam logic [7:0] IDX_DLM   = 8'h17;
  localparam logic [7:0] IDX_FIRST_RESUME_CHAR  = 8'h18;
  localparam logic [7:0] IDX_SECOND_RESUME_CHAR  = 8'h19;
  localparam logic [7:0] IDX_FIRST_STOP_CHAR = 8'h1A;
  localparam logic [7:0] IDX_SECOND_STOP_CHAR = 8'h1B;
  localparam logic [7:0] IDX_UPPER = 8'h1C;
  localparam logic [7:0] IDX_LOWER = 8'h1D;
  // Reset values
  localparam logic [7:0] CPR_RESET   = 8'h20;
  localparam logic [7:0] TCR_RESET   = 8'h00;
  localparam logic [7:0] ZERO_RESET  = 8'h00;
  localparam logic [7:0] DLL_RESET   = 8'h01;
  localparam logic [7:0] UPPER_RESET = 8'h60;
  localparam logic [7:0] LOWER_RESET = 8'h20;
  // Field positions
  localparam int EFR_ENH   = 4;
  localparam int EFR_SPEC  = 5;
  localparam int EFR_ARTS  = 6;
  localparam int EFR_ACTS  = 7;
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_XANY  = 5;
  localparam int MCR_PSEL  = 7;
  localparam int ACR_ADSR  = 2;
  localparam int ACR_ADTR  = 3;
  localparam int IER_LVL5  = 5;
  // Baud timing figures
  localparam logic [8:0] PRESC_ONE = 9'h008;
  localparam logic [8:0] PRESC_STEP = 9'h008;
  localparam logic [3:0] TCR_MIN   = 4'h4;
  localparam logic [4:0] SC_DEFAULT = 5'h10;
  typedef struct packed {
    logic [7:0] data;
    logic       parity_err;
    logic       framing_err;
  } ufc_rx_char_type;
  typedef enum logic [1:0] {
    UFC_FLOW_OFF   = 2'b00,
    UFC_FLOW_PAIR2 = 2'b01,
    UFC_FLOW_PAIR1 = 2'b10,
    UFC_FLOW_BOTH  = 2'b11
  } ufc_flow_type;
  typedef enum logic [1:0] {
    UFC_SRC_NONE = 2'b00,
    UFC_SRC_XOFF = 2'b01,
    UFC_SRC_XON  = 2'b10,
    UFC_SRC_DATA = 2'b11
  } ufc_src_type;
endpackage : ufc_pkg
`default_nettype wire
